// >>> src/fbsr_params.svh
`ifndef FBSR_PARAMS_SVH
`define FBSR_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define FBSR_STAGES 4
`define FBSR_SYNC_W 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FBSR_STAGE_RST 4'h0
`define FBSR_INV_RST 1'h1
`define FBSR_SYNC_RST 7'h00

// ----------------------------------------
// Field positions in the synchronised input word
// ----------------------------------------
`define FBSR_F_PAR_LO 0
`define FBSR_F_PAR_HI 3
`define FBSR_F_KN 4
`define FBSR_F_J 5
`define FBSR_F_MODE 6

`endif

// >>> src/fbsr_pkg.sv
`include "fbsr_params.svh"

package fbsr_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef logic [`FBSR_STAGES-1:0] fbsr_stage_t;
   typedef logic [`FBSR_SYNC_W-1:0] fbsr_sync_t;

   // Action of the serial pair on the first stage, keyed by {j, k_n}
   typedef enum logic [1:0] {
      FBSR_JK_CLEAR  = 2'h0,
      FBSR_JK_HOLD   = 2'h1,
      FBSR_JK_TOGGLE = 2'h2,
      FBSR_JK_SET    = 2'h3
   } fbsr_jk_e;

endpackage : fbsr_pkg

// >>> src/fbsr_sync.sv
`include "fbsr_params.svh"

module fbsr_sync (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pins in, synchronised word out
   input wire fbsr_pkg::fbsr_sync_t pin_in,
   output fbsr_pkg::fbsr_sync_t sync_out
);

   fbsr_pkg::fbsr_sync_t meta_reg;
   fbsr_pkg::fbsr_sync_t meta_next;
   fbsr_pkg::fbsr_sync_t sync_reg;
   fbsr_pkg::fbsr_sync_t sync_next;

   // ----------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------
   always_comb begin
      meta_next = pin_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= `FBSR_SYNC_RST;
         sync_reg <= `FBSR_SYNC_RST;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;

endmodule : fbsr_sync

// >>> src/fbsr_top.sv
// Contract
// RULE1: Mode pin high shifts, low loads parallel
// RULE2: Shift: first stage from pair, others move
// RULE3: Tied serial pair behaves as data input
// RULE4: Load: stages capture parallel, ignore serial
// RULE5: Parallel bit n lands on stage n
// RULE6: Board feeds back outputs for left shift
// RULE7: Clear low forces stages low immediately
// RULE8: Pair: clear, hold, toggle, set
`include "fbsr_params.svh"

module fbsr_top (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Mode and serial pair
   input wire logic shift_not_load_select,
   input wire logic serial_j,
   input wire logic serial_k_n,
   // Parallel data
   input wire fbsr_pkg::fbsr_stage_t parallel_inputs,
   // Asynchronous clear
   input wire logic master_clear_low,
   // Stage outputs
   output fbsr_pkg::fbsr_stage_t stage_outputs,
   output logic last_stage_inv
);

   // ----------------------------------------
   // Input synchronisation
   // ----------------------------------------
   fbsr_pkg::fbsr_sync_t pin_word;
   fbsr_pkg::fbsr_sync_t sync_word;
   logic shift_s;
   logic j_s;
   logic kn_s;
   fbsr_pkg::fbsr_stage_t par_s;

   // Pins act on the stages two edges after they are sampled
   assign pin_word = {shift_not_load_select, serial_j, serial_k_n, parallel_inputs};

   fbsr_sync fbsr_sync_inst (
      .core_clk(core_clk),
      .rst(rst),
      .pin_in(pin_word),
      .sync_out(sync_word)
   );

   assign shift_s = sync_word[`FBSR_F_MODE];
   assign j_s = sync_word[`FBSR_F_J];
   assign kn_s = sync_word[`FBSR_F_KN];
   assign par_s = sync_word[`FBSR_F_PAR_HI:`FBSR_F_PAR_LO];

   // ----------------------------------------
   // Stage register
   // ----------------------------------------
   fbsr_pkg::fbsr_stage_t stage_reg;
   fbsr_pkg::fbsr_stage_t stage_next;
   logic [`FBSR_STAGES-1:1] shifted;
   logic last_inv_reg;
   logic last_inv_next;
   logic first_bit;
   logic clear_any;
   fbsr_pkg::fbsr_jk_e jk_act;

   // Clear release is not synchronised, so keep it away from clock edges
   // RULE7: clear acts without clock
   assign clear_any = rst | ~master_clear_low;

   // RULE2: move stages upward
   genvar gi;
   generate
      for (gi = 1; gi < `FBSR_STAGES; gi++) begin : g_move
         assign shifted[gi] = stage_reg[gi-1];
      end
   endgenerate

   assign jk_act = fbsr_pkg::fbsr_jk_e'({j_s, kn_s});

   always_comb begin
      first_bit = stage_reg[0];
      // RULE8: serial pair action
      // RULE3: tied pair gives data
      case (jk_act)
         fbsr_pkg::FBSR_JK_CLEAR: begin
            first_bit = 1'b0;
         end
         fbsr_pkg::FBSR_JK_HOLD: begin
            first_bit = stage_reg[0];
         end
         fbsr_pkg::FBSR_JK_TOGGLE: begin
            first_bit = ~stage_reg[0];
         end
         fbsr_pkg::FBSR_JK_SET: begin
            first_bit = 1'b1;
         end
         default: begin
            first_bit = stage_reg[0];
         end
      endcase
      // RULE1: mode select
      if (shift_s) begin
         stage_next = {shifted, first_bit};
      end else begin
         // RULE4: parallel capture
         // RULE5: same index load
         stage_next = par_s;
      end
      last_inv_next = ~stage_next[`FBSR_STAGES-1];
   end

   always_ff @(posedge core_clk or posedge clear_any) begin
      if (clear_any) begin
         stage_reg <= `FBSR_STAGE_RST;
         last_inv_reg <= `FBSR_INV_RST;
      end else begin
         stage_reg <= stage_next;
         last_inv_reg <= last_inv_next;
      end
   end

   assign stage_outputs = stage_reg;
   assign last_stage_inv = last_inv_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_shift_taken;
      shift_s;
   endsequence

   sequence s_load_taken;
      !shift_s;
   endsequence

   sequence s_mode_pin_held;
      shift_not_load_select [*3];
   endsequence

   sequence s_load_pin_held;
      (!shift_not_load_select) [*3];
   endsequence

   sequence s_pair_clear;
      s_shift_taken and (!j_s && !kn_s);
   endsequence

   sequence s_pair_set;
      s_shift_taken and (j_s && kn_s);
   endsequence

   a_mode_select_pin: assert property (@(posedge core_clk) disable iff (clear_any) // RULE1
      s_mode_pin_held |=> stage_outputs[3:1] == $past(stage_outputs[2:0]))
      else $error("mode pin high did not shift stages");

   a_shift_move: assert property (@(posedge core_clk) disable iff (clear_any) // RULE2
      s_shift_taken |=> stage_outputs[3:1] == $past(stage_outputs[2:0]))
      else $error("shift did not move stages upward");

   a_tied_pair_data: assert property (@(posedge core_clk) disable iff (clear_any) // RULE3
      s_shift_taken and (j_s == kn_s) |=> stage_outputs[0] == $past(j_s))
      else $error("tied serial pair did not act as data");

   a_load_ignore_serial: assert property (@(posedge core_clk) disable iff (clear_any) // RULE4
      s_load_taken ##1 s_load_taken |=> stage_outputs == $past(par_s)
      && last_stage_inv == ~$past(par_s[3]))
      else $error("parallel load not captured");

   a_load_same_index: assert property (@(posedge core_clk) disable iff (clear_any) // RULE5
      s_load_taken |=> stage_outputs == $past(parallel_inputs, 3))
      else $error("parallel bit landed on wrong stage");

   a_clear_forces_low: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      !master_clear_low |-> stage_outputs == `FBSR_STAGE_RST && last_stage_inv)
      else $error("clear did not force stages low");

   a_pair_toggle: assert property (@(posedge core_clk) disable iff (clear_any) // RULE8
      s_shift_taken and (j_s && !kn_s) |=> stage_outputs[0] != $past(stage_outputs[0]))
      else $error("serial pair did not toggle first stage");

   a_pair_hold: assert property (@(posedge core_clk) disable iff (clear_any) // RULE8
      s_shift_taken and (!j_s && kn_s) |=> $stable(stage_outputs[0]))
      else $error("serial pair did not hold first stage");

   // ----------------------------------------
   // Load and mode checks
   // ----------------------------------------

   a_mode_load_pin: assert property (@(posedge core_clk) disable iff (clear_any) // RULE1
      s_load_pin_held |=> stage_outputs == $past(par_s))
      else $error("mode pin low did not load stages");

   a_load_skip_pair: assert property (@(posedge core_clk) disable iff (clear_any) // RULE4
      s_load_taken and (j_s != kn_s) |=> stage_outputs[0] == $past(par_s[0]))
      else $error("serial pair disturbed a parallel load");

   // RULE5: per-stage load
   generate
      for (gi = 0; gi < `FBSR_STAGES; gi++) begin : g_load_bit
         a_load_bit_lands: assert property (@(posedge core_clk) disable iff (clear_any) // RULE5
            s_load_taken |=> stage_outputs[gi] == $past(par_s[gi]))
            else $error("parallel bit landed on another stage");
      end
   endgenerate

   // ----------------------------------------
   // Serial pair checks
   // ----------------------------------------

   a_pair_clear: assert property (@(posedge core_clk) disable iff (clear_any) // RULE8
      s_pair_clear |=> !stage_outputs[0])
      else $error("serial pair did not clear first stage");

   a_pair_set: assert property (@(posedge core_clk) disable iff (clear_any) // RULE8
      s_pair_set |=> stage_outputs[0])
      else $error("serial pair did not set first stage");

   // ----------------------------------------
   // Inverted output check
   // ----------------------------------------

   a_inv_last_stage: assert property (@(posedge core_clk) disable iff (rst) // RULE7
      last_stage_inv != stage_outputs[3])
      else $error("inverted last stage output disagrees");

endmodule : fbsr_top

// >>> tb/fbsr_board.sv
module fbsr_board (
   // Clock
   input wire logic core_clk,
   // Requests from the bench
   input wire logic feedback_en,
   input wire logic req_mode,
   input wire logic req_j,
   input wire logic req_k_n,
   input wire fbsr_pkg::fbsr_stage_t req_par,
   // Device side
   input wire fbsr_pkg::fbsr_stage_t stage_outputs,
   output logic shift_not_load_select,
   output logic serial_j,
   output logic serial_k_n,
   output fbsr_pkg::fbsr_stage_t parallel_inputs
);
   timeunit 1ns;
   timeprecision 100ps;
   logic fb;
   logic [6:0] req;

   initial begin
      {shift_not_load_select, serial_j, serial_k_n, parallel_inputs} = 7'h00;
   end

   // Requests are taken at the edge, so the bench may change them just after it
   always @(posedge core_clk) begin
      fb = feedback_en;
      req = {req_mode, req_j, req_k_n, req_par};
      #1;
      {shift_not_load_select, serial_j, serial_k_n, parallel_inputs} = req;
      if (fb) begin
         shift_not_load_select = 1'h0;
         parallel_inputs = {1'h0, stage_outputs[3:1]};
      end
   end
endmodule : fbsr_board

// >>> tb/fbsr_top_tb.sv
module fbsr_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic master_clear_low = 1'h1;
   logic feedback_en = 1'h0;
   logic req_mode = 1'h0;
   logic req_j = 1'h0;
   logic req_k_n = 1'h0;
   fbsr_pkg::fbsr_stage_t req_par = 4'h0;
   logic shift_not_load_select, serial_j, serial_k_n;
   fbsr_pkg::fbsr_stage_t parallel_inputs, stage_outputs;
   logic last_stage_inv;
   int mismatches = 0;
   int total_checks = 0;
   // Rows: mode, j, k_n, parallel, expected stages
   logic [10:0] rows [10] = '{11'h0AA, 11'h705, 11'h40A, 11'h504, 11'h609,
                              11'h602, 11'h3FF, 11'h200, 11'h701, 11'h503};

   always #2.5 core_clk = ~core_clk;

   fbsr_board fbsr_board_inst (.core_clk(core_clk), .feedback_en(feedback_en), .req_mode(req_mode),
      .req_j(req_j), .req_k_n(req_k_n), .req_par(req_par), .stage_outputs(stage_outputs),
      .shift_not_load_select(shift_not_load_select), .serial_j(serial_j), .serial_k_n(serial_k_n),
      .parallel_inputs(parallel_inputs));

   fbsr_top fbsr_top_inst (.core_clk(core_clk), .rst(rst), .shift_not_load_select(shift_not_load_select),
      .serial_j(serial_j), .serial_k_n(serial_k_n), .parallel_inputs(parallel_inputs),
      .master_clear_low(master_clear_low), .stage_outputs(stage_outputs), .last_stage_inv(last_stage_inv));

   task automatic end_sim();
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check_out(input fbsr_pkg::fbsr_stage_t exp);
      total_checks++;
      if (stage_outputs !== exp || last_stage_inv !== ~exp[3]) begin
         mismatches++;
         $display("ERROR %0t stages %h inv %b expected %h", $time, stage_outputs, last_stage_inv, exp);
      end
   endtask : check_out

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   // Feedback makes the change time depend on the pipeline, so wait for it
   task automatic wait_change(input fbsr_pkg::fbsr_stage_t exp);
      fbsr_pkg::fbsr_stage_t old;
      old = stage_outputs;
      for (int n = 0; n < 10 && stage_outputs === old; n++) begin
         step(1);
      end
      check_out(exp);
   endtask : wait_change

   initial begin
      #(5 * 300);
      mismatches++;
      end_sim();
   end

   initial begin
      step(3);
      check_out(4'h0);
      rst = 1'h0;
      // Rows act four edges after they are requested
      for (int i = 0; i < 14; i++) begin
         if (i < 10) begin
            {req_mode, req_j, req_k_n, req_par} = rows[i][10:4];
         end
         if (i >= 4) check_out(rows[i - 4][3:0]);
         step(1);
      end
      // ----------------------------------------
      // Clear between edges and across edges
      // ----------------------------------------
      {req_mode, req_par} = 5'h06;
      step(5);
      master_clear_low = 1'h0;
      #0.5 check_out(4'h0);
      step(3);
      check_out(4'h0);
      master_clear_low = 1'h1;
      step(1);
      check_out(4'h6);
      // ----------------------------------------
      // Downward shift through board feedback
      // ----------------------------------------
      req_par = 4'h8;
      step(5);
      check_out(4'h8);
      feedback_en = 1'h1;
      wait_change(4'h4);
      wait_change(4'h2);
      wait_change(4'h1);
      wait_change(4'h0);
      end_sim();
   end
endmodule : fbsr_top_tb
